// File: dv/module_power_key_reset_control_test.sv
/*
 Testbench: host and device joined by the link, driven by host commands.
 Assumes shortened windows and a four-cycle sequence phase.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module module_power_key_reset_control_test;
  localparam int SEQ = 4;
  // Shortened windows and holds, in cycles
  localparam int ON_MIN = 10;
  localparam int ON_MAX = 20;
  localparam int OFF_MIN = 30;
  localparam int OFF_MAX = 40;
  localparam int RST_MIN = 7;
  localparam int RST_MAX = 10;
  localparam int ON_HOLD = 15;
  localparam int OFF_HOLD = 35;
  localparam int RST_HOLD = 8;
  localparam int SETTLE = 5;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic supply_en = 1'b1;
  logic supply_low = 1'b0;
  logic soft_shutdown_cmd = 1'b0;
  logic soft_restart_cmd = 1'b0;
  logic cmd_valid = 1'b0;
  pkr_pkg::pkr_cmd_t cmd = pkr_pkg::PKR_CMD_NONE;
  logic busy, module_on, powered_on, core_reset, net_logout;
  logic seen_lo = 1'b0;
  logic seen_rst = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  pkr_link_if link ();
  pkr_host #(.ON_HOLD(ON_HOLD), .OFF_HOLD(OFF_HOLD), .RST_HOLD(RST_HOLD),
    .SETTLE(SETTLE)) u_pkr_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link), .supply_en(supply_en),
    .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .module_on(module_on));
  pkr_device #(.ON_MIN(ON_MIN), .ON_MAX(ON_MAX), .OFF_MIN(OFF_MIN), .OFF_MAX(OFF_MAX),
    .RST_MIN(RST_MIN), .RST_MAX(RST_MAX), .SEQ(SEQ)) u_pkr_device (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link), .supply_low(supply_low),
    .soft_shutdown_cmd(soft_shutdown_cmd), .soft_restart_cmd(soft_restart_cmd),
    .powered_on(powered_on), .core_reset(core_reset), .net_logout(net_logout));
  pkr_link_asserts #(.ON_MIN(ON_MIN), .ON_MAX(ON_MAX), .OFF_MIN(OFF_MIN), .OFF_MAX(OFF_MAX),
    .ON_HOLD(ON_HOLD), .OFF_HOLD(OFF_HOLD), .RST_HOLD(RST_HOLD),
    .LIM(SEQ + 4)) u_pkr_link_asserts (
    .sys_clk(sys_clk), .reset_n(reset_n), .power_button_oe(link.power_button_oe),
    .restart_oe(link.restart_oe), .aux_rail_out(link.aux_rail_out),
    .power_button_low(link.power_button_low), .restart_low(link.restart_low));
  // Clock and sticky flags for short-lived states
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (net_logout) seen_lo <= 1'b1;
    if (core_reset) seen_rst <= 1'b1;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic send(input pkr_pkg::pkr_cmd_t c);
    int i;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = c;
    repeat (2) @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge sys_clk);
    if (i == 100) begin num_errors++; tally_and_finish(); end
  endtask
  task automatic wait_pwr(input logic e);
    int i;
    for (i = 0; i < 200 && powered_on !== e; i++) @(negedge sys_clk);
    if (i == 200) begin num_errors++; tally_and_finish(); end
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    send(pkr_pkg::PKR_CMD_OFF);
    send(pkr_pkg::PKR_CMD_RESTART);
    repeat (6) @(negedge sys_clk);
    `CHK("aux_rail_out", 1'b0, link.aux_rail_out)
    $display("test reject done");
    send(pkr_pkg::PKR_CMD_ON);
    wait_pwr(1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK("aux_rail_out", 1'b1, link.aux_rail_out)
    `CHK("module_on", 1'b1, module_on)
    `CHK("core_reset", 1'b0, core_reset)
    $display("test power on done");
    seen_rst = 1'b0;
    send(pkr_pkg::PKR_CMD_RESTART);
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    `CHK("hw restart", 1'b1, seen_rst)
    seen_rst = 1'b0;
    pulse(soft_restart_cmd);
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    `CHK("soft restart", 1'b1, seen_rst)
    $display("test restart done");
    seen_lo = 1'b0;
    send(pkr_pkg::PKR_CMD_OFF);
    wait_pwr(1'b0);
    repeat (SEQ + 3) @(negedge sys_clk);
    `CHK("key logout", 1'b1, seen_lo)
    `CHK("aux_rail_out", 1'b0, link.aux_rail_out)
    send(pkr_pkg::PKR_CMD_ON);
    wait_pwr(1'b1);
    seen_lo = 1'b0;
    pulse(soft_shutdown_cmd);
    wait_pwr(1'b0);
    repeat (SEQ + 3) @(negedge sys_clk);
    `CHK("soft logout", 1'b1, seen_lo)
    `CHK("aux_rail_out", 1'b0, link.aux_rail_out)
    $display("test power off done");
    send(pkr_pkg::PKR_CMD_ON);
    wait_pwr(1'b1);
    seen_lo = 1'b0;
    fork
      send(pkr_pkg::PKR_CMD_ON);
      begin repeat (3) @(negedge sys_clk); pulse(soft_shutdown_cmd); end
    join
    repeat (SEQ + 4) @(negedge sys_clk);
    `CHK("held logout", 1'b1, seen_lo)
    `CHK("repowered", 1'b1, powered_on)
    $display("test held key done");
    seen_lo = 1'b0;
    clk_en = 1'b0;
    pulse(soft_shutdown_cmd);
    repeat (SEQ + 4) @(negedge sys_clk);
    `CHK("frozen aux", 1'b1, link.aux_rail_out)
    `CHK("frozen logout", 1'b0, seen_lo)
    clk_en = 1'b1;
    $display("test clock enable done");
    seen_lo = 1'b0;
    @(negedge sys_clk);
    supply_low = 1'b1;
    @(negedge sys_clk);
    `CHK("aux_rail_out", 1'b0, link.aux_rail_out)
    repeat (SEQ + 2) @(negedge sys_clk);
    `CHK("powered_on", 1'b0, powered_on)
    `CHK("sag logout", 1'b0, seen_lo)
    supply_low = 1'b0;
    $display("test supply sag done");
    `CHK("off before cut", 1'b0, module_on)
    supply_en = 1'b0;
    supply_low = 1'b1;
    repeat (2) @(negedge sys_clk);
    supply_en = 1'b1;
    supply_low = 1'b0;
    send(pkr_pkg::PKR_CMD_ON);
    `CHK("unsettled busy", 1'b0, busy)
    `CHK("unsettled key", 1'b0, link.power_button_low)
    repeat (SETTLE + 2) @(negedge sys_clk);
    send(pkr_pkg::PKR_CMD_ON);
    wait_pwr(1'b1);
    `CHK("settled on", 1'b1, powered_on)
    $display("test supply settle done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: dv/pkr_link_asserts.sv
/*
 Checker for the key and restart link between the host and device ends.
 Assumes its windows and holds match the parameters of both instances.
*/
`timescale 1ns/1ps
`default_nettype none
module pkr_link_asserts #(
  parameter int ON_MIN = 10, ON_MAX = 20, OFF_MIN = 30, OFF_MAX = 40,
  parameter int ON_HOLD = 15, OFF_HOLD = 35, RST_HOLD = 8, LIM = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic power_button_oe,
  input wire logic restart_oe,
  input wire logic aux_rail_out,
  input wire logic power_button_low,
  input wire logic restart_low
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  int key_len_r;
  int rst_len_r;
  int since_rel_r;
  // Low pulse lengths and cycles since the last key release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_len_r <= 0;
      rst_len_r <= 0;
      since_rel_r <= 99;
    end else begin
      key_len_r <= power_button_low ? key_len_r + 1 : 0;
      rst_len_r <= restart_low ? rst_len_r + 1 : 0;
      if (!power_button_low && key_len_r != 0) since_rel_r <= 0;
      else if (since_rel_r < 99) since_rel_r <= since_rel_r + 1;
    end
  end
  a_key_on_window: assert property ($fell(power_button_low) && !aux_rail_out &&
    key_len_r inside {[ON_MIN:ON_MAX]} |-> ##[1:2] aux_rail_out) else $error("no power on");
  a_key_on_reject: assert property ($fell(power_button_low) && !aux_rail_out &&
    !(key_len_r inside {[ON_MIN:ON_MAX]}) |-> ##1 !aux_rail_out [*3]) else $error("bad on");
  a_key_off_window: assert property ($fell(power_button_low) && aux_rail_out &&
    key_len_r inside {[OFF_MIN:OFF_MAX]} |-> ##[1:LIM] !aux_rail_out) else $error("no off");
  a_restart_keeps_rail: assert property ($fell(restart_low) && aux_rail_out
    |-> ##1 aux_rail_out [*8]) else $error("rail lost on restart");
  a_restart_off_ignored: assert property ($fell(restart_low) && !aux_rail_out
    |-> ##1 !aux_rail_out [*4]) else $error("restart woke device");
  a_rail_after_key: assert property ($rose(aux_rail_out) |-> since_rel_r < 3)
    else $error("rail rose without key release");
  a_key_hold_len: assert property ($fell(power_button_low)
    |-> key_len_r == ON_HOLD || key_len_r == OFF_HOLD) else $error("key hold length");
  a_restart_hold_len: assert property ($fell(restart_low) |-> rst_len_r == RST_HOLD)
    else $error("restart hold length");
  a_one_line_low: assert property (!(power_button_oe && restart_oe))
    else $error("both lines low");
  c_power_on: cover property ($rose(aux_rail_out));
  c_power_off: cover property ($fell(aux_rail_out));
  c_restart: cover property ($fell(restart_low) && aux_rail_out);
endmodule
`default_nettype wire

// File: hdl/pkr_device.sv
/*
 Device end: measures low pulses on the power key and restart lines and runs
 the power state, with software shutdown and restart and supply-sag power-off.
 Assumes the link inputs are synchronous to sys_clk.
*/
// How it works
// - Off: key low 100ms-2s then release powers on
// - On: key low 3s-8s then release powers down
// - On: restart low 700ms-1s then release resets
// - Host waits 30ms after supply before key
// - Supply sag forces immediate abnormal power-off
// - Soft shutdown command does orderly power-down
// - Key held low after soft shutdown repowers
// - Soft restart command equals hardware reset
// - Host shuts down before removing supply; pkr_host has no shutdown step, supply_en only restarts its settle count
// - Aux rail driven in every state but off
`timescale 1ns/1ps
`default_nettype none
module pkr_device #(
  parameter int unsigned ON_MIN = pkr_pkg::ON_MIN_CYC,
  parameter int unsigned ON_MAX = pkr_pkg::ON_MAX_CYC,
  parameter int unsigned OFF_MIN = pkr_pkg::OFF_MIN_CYC,
  parameter int unsigned OFF_MAX = pkr_pkg::OFF_MAX_CYC,
  parameter int unsigned RST_MIN = pkr_pkg::RST_MIN_CYC,
  parameter int unsigned RST_MAX = pkr_pkg::RST_MAX_CYC,
  parameter int unsigned SEQ = pkr_pkg::SEQ_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  pkr_link_if.device link,
  input wire logic supply_low,
  input wire logic soft_shutdown_cmd,
  input wire logic soft_restart_cmd,
  output logic powered_on,
  output logic core_reset,
  output logic net_logout
);
  pkr_pkg::pkr_state_t state_r;
  logic [pkr_pkg::CNT_W-1:0] key_cnt_r;
  logic [pkr_pkg::CNT_W-1:0] rst_cnt_r;
  logic [pkr_pkg::CNT_W-1:0] seq_cnt_r;
  logic key_prev_r;
  logic rst_prev_r;
  logic key_rel;
  logic rst_rel;
  logic seq_done;

  // True when a count lies inside a closed window
  function automatic logic in_win(input logic [pkr_pkg::CNT_W-1:0] c,
                                  input int unsigned lo, input int unsigned hi);
    in_win = (c >= pkr_pkg::CNT_W'(lo)) && (c <= pkr_pkg::CNT_W'(hi));
  endfunction

  // One step of a saturating up-count, so a stuck line never wraps to a short pulse
  function automatic logic [pkr_pkg::CNT_W-1:0] sat_inc(input logic [pkr_pkg::CNT_W-1:0] c);
    sat_inc = (c == '1) ? c : c + 1'b1;
  endfunction

  // Release events on the two lines
  assign key_rel = key_prev_r && !link.power_button_low;
  assign rst_rel = rst_prev_r && !link.restart_low;
  assign seq_done = seq_cnt_r == pkr_pkg::CNT_W'(SEQ - 1);

  // Previous key line level for release detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_prev_r <= 1'b0;
    end else if (clk_en) begin
      key_prev_r <= link.power_button_low;
    end
  end

  // Previous restart line level for release detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_prev_r <= 1'b0;
    end else if (clk_en) begin
      rst_prev_r <= link.restart_low;
    end
  end

  // Key low-time counter, saturating, cleared while the line is high
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_cnt_r <= '0;
    end else if (clk_en) begin
      if (!link.power_button_low) begin
        key_cnt_r <= '0;
      end else begin
        key_cnt_r <= sat_inc(key_cnt_r);
      end
    end
  end

  // Restart low-time counter, same scheme as the key counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_r <= '0;
    end else if (clk_en) begin
      if (!link.restart_low) begin
        rst_cnt_r <= '0;
      end else begin
        rst_cnt_r <= sat_inc(rst_cnt_r);
      end
    end
  end

  // Sequence timer for boot, shutdown and reset phases
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r == pkr_pkg::PKR_OFF || state_r == pkr_pkg::PKR_ON || seq_done) begin
        seq_cnt_r <= '0;
      end else begin
        seq_cnt_r <= seq_cnt_r + 1'b1;
      end
    end
  end

  // Power state machine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= pkr_pkg::PKR_OFF;
    end else if (clk_en) begin
      if (supply_low) begin
        state_r <= pkr_pkg::PKR_OFF;
      end else begin
        unique case (state_r)
          pkr_pkg::PKR_OFF: begin
            if (key_rel && in_win(key_cnt_r, ON_MIN, ON_MAX)) begin
              state_r <= pkr_pkg::PKR_BOOT;
            end
          end
          pkr_pkg::PKR_BOOT: begin
            if (seq_done) begin
              state_r <= pkr_pkg::PKR_ON;
            end
          end
          pkr_pkg::PKR_ON: begin
            if (soft_shutdown_cmd) begin
              state_r <= pkr_pkg::PKR_SHUTDOWN;
            end else if (key_rel && in_win(key_cnt_r, OFF_MIN, OFF_MAX)) begin
              state_r <= pkr_pkg::PKR_SHUTDOWN;
            end else if (soft_restart_cmd) begin
              state_r <= pkr_pkg::PKR_RESET;
            end else if (rst_rel && in_win(rst_cnt_r, RST_MIN, RST_MAX)) begin
              state_r <= pkr_pkg::PKR_RESET;
            end
          end
          pkr_pkg::PKR_SHUTDOWN: begin
            if (seq_done) begin
              // Key held low at the end of shutdown brings the module back
              state_r <= link.power_button_low ? pkr_pkg::PKR_BOOT : pkr_pkg::PKR_OFF;
            end
          end
          pkr_pkg::PKR_RESET: begin
            if (seq_done) begin
              state_r <= pkr_pkg::PKR_BOOT;
            end
          end
          default: state_r <= pkr_pkg::PKR_OFF;
        endcase
      end
    end
  end

  // Power-good flag, high only in the on state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      powered_on <= 1'b0;
    end else if (clk_en) begin
      powered_on <= state_r == pkr_pkg::PKR_ON;
    end
  end

  // Core reset, held in every state but on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_reset <= 1'b1;
    end else if (clk_en) begin
      core_reset <= state_r != pkr_pkg::PKR_ON;
    end
  end

  // Logout strobe, only during an orderly shutdown
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      net_logout <= 1'b0;
    end else if (clk_en) begin
      net_logout <= state_r == pkr_pkg::PKR_SHUTDOWN;
    end
  end

  // Aux rail, dropped at once on a supply sag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.aux_rail_out <= 1'b0;
    end else if (clk_en) begin
      link.aux_rail_out <= state_r != pkr_pkg::PKR_OFF && !supply_low;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pkr_host.sv
/*
 Host end: on a one-cycle command it drives the power key or restart line low
 for a set time, after a settle delay following supply enable.
 Assumes the aux rail input is synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pkr_host #(
  parameter int unsigned ON_HOLD = (pkr_pkg::ON_MIN_CYC + pkr_pkg::ON_MAX_CYC) / 2,
  parameter int unsigned OFF_HOLD = (pkr_pkg::OFF_MIN_CYC + pkr_pkg::OFF_MAX_CYC) / 2,
  parameter int unsigned RST_HOLD = (pkr_pkg::RST_MIN_CYC + pkr_pkg::RST_MAX_CYC) / 2,
  parameter int unsigned SETTLE = pkr_pkg::SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  pkr_link_if.host link,
  input wire logic supply_en,
  input wire logic cmd_valid,
  input wire pkr_pkg::pkr_cmd_t cmd,
  output logic busy,
  output logic module_on
);
  logic [pkr_pkg::CNT_W-1:0] settle_cnt_r;
  logic [pkr_pkg::CNT_W-1:0] hold_cnt_r;
  logic ready;

  assign ready = settle_cnt_r == pkr_pkg::CNT_W'(SETTLE);

  // Supply settle counter; restarts whenever supply is off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_r <= '0;
    end else if (clk_en) begin
      if (!supply_en) begin
        settle_cnt_r <= '0;
      end else if (!ready) begin
        settle_cnt_r <= settle_cnt_r + 1'b1;
      end
    end
  end

  // Pulse generator on the two lines
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_r <= '0;
      link.power_button_oe <= 1'b0;
      link.restart_oe <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      if (busy) begin
        if (hold_cnt_r == pkr_pkg::CNT_W'(1)) begin
          link.power_button_oe <= 1'b0;
          link.restart_oe <= 1'b0;
          busy <= 1'b0;
        end
        hold_cnt_r <= hold_cnt_r - 1'b1;
      end else if (cmd_valid && ready) begin
        unique case (cmd)
          pkr_pkg::PKR_CMD_ON: begin
            hold_cnt_r <= pkr_pkg::CNT_W'(ON_HOLD);
            link.power_button_oe <= 1'b1;
            busy <= 1'b1;
          end
          pkr_pkg::PKR_CMD_OFF: begin
            hold_cnt_r <= pkr_pkg::CNT_W'(OFF_HOLD);
            link.power_button_oe <= 1'b1;
            busy <= 1'b1;
          end
          pkr_pkg::PKR_CMD_RESTART: begin
            hold_cnt_r <= pkr_pkg::CNT_W'(RST_HOLD);
            link.restart_oe <= 1'b1;
            busy <= 1'b1;
          end
          pkr_pkg::PKR_CMD_NONE: begin
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

  // Module power state seen on the aux rail
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      module_on <= 1'b0;
    end else if (clk_en) begin
      module_on <= link.aux_rail_out;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pkr_link_if.sv
/*
 Interface joining the host and the device: two open-drain lines and the aux rail.
 Assumes open-drain lines with pull-ups; a line is low while any enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
interface pkr_link_if;
  logic power_button_oe;
  logic restart_oe;
  logic aux_rail_out;
  logic power_button_low;
  logic restart_low;
  // Wired-AND with pull-up: the host is the only driver
  assign power_button_low = power_button_oe;
  assign restart_low = restart_oe;
  modport host (output power_button_oe, output restart_oe, input aux_rail_out);
  modport device (input power_button_low, input restart_low, output aux_rail_out);
endinterface
`default_nettype wire

// File: hdl/pkr_pkg.sv
/*
 Package for the power key and restart sequencer: timing constants and state types.
 Assumes a 125 MHz system clock shared by both ends.
*/
package pkr_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  // Times in milliseconds
  localparam int unsigned ON_MIN_MS = 100;
  localparam int unsigned ON_MAX_MS = 2000;
  localparam int unsigned OFF_MIN_MS = 3000;
  localparam int unsigned OFF_MAX_MS = 8000;
  localparam int unsigned RST_MIN_MS = 700;
  localparam int unsigned RST_MAX_MS = 1000;
  localparam int unsigned SUPPLY_SETTLE_MS = 30;
  localparam int unsigned TICKS_PER_MS = CLK_HZ / 1000;
  // Cycle counts: least times are exact multiples, so rounding is moot
  localparam int unsigned ON_MIN_CYC = ON_MIN_MS * TICKS_PER_MS;
  localparam int unsigned ON_MAX_CYC = ON_MAX_MS * TICKS_PER_MS;
  localparam int unsigned OFF_MIN_CYC = OFF_MIN_MS * TICKS_PER_MS;
  localparam int unsigned OFF_MAX_CYC = OFF_MAX_MS * TICKS_PER_MS;
  localparam int unsigned RST_MIN_CYC = RST_MIN_MS * TICKS_PER_MS;
  localparam int unsigned RST_MAX_CYC = RST_MAX_MS * TICKS_PER_MS;
  localparam int unsigned SETTLE_CYC = SUPPLY_SETTLE_MS * TICKS_PER_MS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SEQ_CYC = 16;
  // Device power states
  typedef enum logic [2:0] {
    PKR_OFF, PKR_BOOT, PKR_ON, PKR_SHUTDOWN, PKR_RESET
  } pkr_state_t;
  // Host command kinds
  typedef enum logic [1:0] {
    PKR_CMD_NONE, PKR_CMD_ON, PKR_CMD_OFF, PKR_CMD_RESTART
  } pkr_cmd_t;
endpackage
